// >>> rtl/lcdc_config.v
// Configuration state of a 48 by 84 graphic LCD driver.
// Assumes a serial front end delivering decoded bytes as one-cycle strobes on clk.
//
// Notes on behaviour
// RULE1 - Reset gives power-down set, horizontal addressing and basic instruction page.
// RULE2 - Reset clears display mode, addresses, coefficient, bias and voltage value.
// RULE3 - After reset oscillator stops, external clock usable, display RAM untouched.
// RULE4 - Power-down holds drivers low, generators off and oscillator stopped.
// RULE5 - Power-down keeps command decoding and RAM writes working.
// RULE6 - Direction bit 0 sequences horizontally, 1 vertically.
// RULE7 - Page 0 runs display, bank, column commands; page 1 extended; both pages others.
// RULE8 - Display mode 00 blank, 10 normal, 01 all on, 11 inverse.
// RULE9 - Three-bit bank field 0 to 5 sets the bank pointer.
// RULE10 - Seven-bit column field sets the column pointer, 0 to 83.
// RULE11 - Two-bit field selects one of four temperature coefficients.
// RULE12 - Bias codes map to n of 7,6,5,4,factory,2,1,0.
// RULE13 - Voltage code is pin offset plus calibration plus twice voltage value.
// RULE14 - Pin offset is five-bit two's complement from static pins.
// RULE15 - Calibration offset is five-bit two's complement from factory storage.
// RULE16 - Voltage value is a seven-bit register written only by command.
// RULE17 - Voltage value zero switches the charge pump off.
// RULE18 - Host keeps voltage value in the range of its coefficient.
// RULE19 - Function set is 00100 plus power, direction, page bits, mode line low.
// RULE20 - Offsets are sign-extended and the sum keeps eight bits, no saturation.
// RULE21 - New field values apply from the cycle after the command is decoded; the temperature coefficient waits for the next byte.
`timescale 1ns/1ps
`include "lcdc_defs.vh"
module lcdc_config #(
   parameter [4:0] CAL_OFFSET = 5'h0_0,
   parameter [2:0] FACTORY_BIAS_N = 3'h4
) (
   input wire clk,
   input wire arst_n,
   input wire byte_valid,
   input wire [7:0] byte_data,
   input wire byte_is_data,
   input wire [4:0] pin_voltage_offset_pins,
   input wire ext_clk_select,
   output reg power_down_flag,
   output reg addr_vertical,
   output reg page_extended,
   output reg [1:0] display_mode,
   output reg [2:0] bank_addr,
   output reg [6:0] col_addr,
   output reg [1:0] temp_coeff_select,
   output reg [2:0] bias_select,
   output reg [6:0] host_voltage_value,
   output reg ram_we,
   output reg [2:0] ram_bank,
   output reg [6:0] ram_col,
   output reg [7:0] ram_wdata,
   output wire [7:0] operating_voltage_code,
   output wire [2:0] bias_n,
   output wire [3:0] bias_divisor,
   output wire osc_enable,
   output wire generators_on,
   output wire pump_on,
   output wire drivers_grounded,
   output wire pixel_force_on,
   output wire pixel_invert,
   output wire pixel_blank
);
   reg [4:0] os_sync1;
   reg [4:0] os_sync2;
   reg osc_run;
   reg tc_pending;
   reg [1:0] tc_value;
   reg [2:0] next_bank;
   reg [6:0] next_col;
   wire pump_vpr;
   wire cmd = byte_valid & ~byte_is_data;
   wire wr = byte_valid & byte_is_data;
   wire is_fset = cmd & ((byte_data & `LCDC_FSET_MASK) == `LCDC_FSET_CODE); // [RULE19]
   wire basic = cmd & ~page_extended; // [RULE7]
   wire ext = cmd & page_extended; // [RULE7]
   wire is_disp = basic & ((byte_data & `LCDC_DISP_MASK) == `LCDC_DISP_CODE);
   wire is_bank = basic & ((byte_data & `LCDC_BANK_MASK) == `LCDC_BANK_CODE);
   wire is_col = basic & byte_data[7];
   wire is_tc = ext & ((byte_data & `LCDC_TC_MASK) == `LCDC_TC_CODE);
   wire is_bias = ext & ((byte_data & `LCDC_BIAS_MASK) == `LCDC_BIAS_CODE);
   wire is_vpr = ext & byte_data[7];
   // Static pins still cross domains, so they pass two flip-flops. [RULE14]
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         os_sync1 <= 5'h0_0;
         os_sync2 <= 5'h0_0;
      end else begin
         os_sync1 <= pin_voltage_offset_pins;
         os_sync2 <= os_sync1;
      end
   end
   // Pointer advance after each data byte, wrapping at the last address. [RULE6]
   always @* begin
      next_bank = bank_addr;
      next_col = col_addr;
      if (addr_vertical) begin
         if (bank_addr == `LCDC_BANK_LAST) begin
            next_bank = 3'h0;
            next_col = (col_addr == `LCDC_COL_LAST) ? 7'h0_0 : col_addr + 7'h0_1;
         end else begin
            next_bank = bank_addr + 3'h1;
         end
      end else begin
         if (col_addr == `LCDC_COL_LAST) begin
            next_col = 7'h0_0;
            next_bank = (bank_addr == `LCDC_BANK_LAST) ? 3'h0 : bank_addr + 3'h1;
         end else begin
            next_col = col_addr + 7'h0_1;
         end
      end
   end
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         power_down_flag <= `LCDC_RST_PD; // [RULE1]
         addr_vertical <= `LCDC_RST_DIR; // [RULE1]
         page_extended <= `LCDC_RST_PAGE; // [RULE1]
         display_mode <= `LCDC_MODE_BLANK; // [RULE2]
         bank_addr <= 3'h0; // [RULE2]
         col_addr <= 7'h0_0; // [RULE2]
         temp_coeff_select <= 2'h0; // [RULE2]
         bias_select <= 3'h0; // [RULE2]
         host_voltage_value <= 7'h0_0; // [RULE2]
         tc_pending <= 1'b0;
         tc_value <= 2'h0;
         osc_run <= 1'b0; // [RULE3]
         ram_we <= 1'b0;
         ram_bank <= 3'h0;
         ram_col <= 7'h0_0;
         ram_wdata <= 8'h0_0;
      end else begin
         ram_we <= 1'b0;
         // The oscillator only runs once power-down has been left. [RULE3] [RULE4]
         osc_run <= ~power_down_flag;
         // Coefficient commands wait for the next byte of either kind.
         if (byte_valid && tc_pending) begin
            temp_coeff_select <= tc_value; // [RULE11]
            tc_pending <= 1'b0;
         end
         if (is_tc) begin
            tc_value <= byte_data[1:0];
            tc_pending <= 1'b1;
         end
         if (is_fset) begin
            power_down_flag <= byte_data[`LCDC_BIT_PD]; // [RULE19] [RULE21]
            addr_vertical <= byte_data[`LCDC_BIT_DIR];
            page_extended <= byte_data[`LCDC_BIT_PAGE];
         end
         if (is_disp) begin
            display_mode <= {byte_data[2], byte_data[0]}; // [RULE8]
         end
         if (is_bank) begin
            bank_addr <= byte_data[2:0]; // [RULE9]
         end
         if (is_col) begin
            col_addr <= byte_data[6:0]; // [RULE10]
         end
         if (is_bias) begin
            bias_select <= byte_data[2:0];
         end
         if (is_vpr) begin
            host_voltage_value <= byte_data[6:0]; // [RULE16]
         end
         // Data writes go through in power-down too; RAM itself is never cleared. [RULE5] [RULE3]
         if (wr) begin
            ram_we <= 1'b1;
            ram_bank <= bank_addr;
            ram_col <= col_addr;
            ram_wdata <= byte_data;
            bank_addr <= next_bank; // [RULE6]
            col_addr <= next_col;
         end
      end
   end
   lcdc_vop u_vop (
      .pin_voltage_offset(os_sync2),
      .cal_offset(CAL_OFFSET),
      .host_voltage_value(host_voltage_value),
      .operating_voltage_code(operating_voltage_code),
      .pump_on(pump_vpr)
   );
   lcdc_bias u_bias (
      .bias_select(bias_select),
      .factory_n(FACTORY_BIAS_N),
      .bias_n(bias_n),
      .bias_divisor(bias_divisor)
   );
   // External clock operation remains possible whatever the oscillator does. [RULE3]
   assign osc_enable = osc_run & ~power_down_flag & ~ext_clk_select; // [RULE4]
   assign generators_on = ~power_down_flag; // [RULE4]
   assign pump_on = pump_vpr & ~power_down_flag; // [RULE17] [RULE4]
   assign drivers_grounded = power_down_flag; // [RULE4]
   assign pixel_blank = (display_mode == `LCDC_MODE_BLANK); // [RULE8]
   assign pixel_force_on = (display_mode == `LCDC_MODE_ALLON);
   assign pixel_invert = (display_mode == `LCDC_MODE_INVERSE);
endmodule

// >>> rtl/lcdc_defs.vh
// Constants for the LCD driver configuration state block.
// Assumes inclusion by bare name from the rtl modules.
`ifndef LCDC_DEFS_VH
`define LCDC_DEFS_VH
`define LCDC_FSET_MASK 8'hF_8
`define LCDC_FSET_CODE 8'h2_0
`define LCDC_BIT_PD 2
`define LCDC_BIT_DIR 1
`define LCDC_BIT_PAGE 0
`define LCDC_RST_PD 1'h1
`define LCDC_RST_DIR 1'h0
`define LCDC_RST_PAGE 1'h0
`define LCDC_DISP_MASK 8'hF_A
`define LCDC_DISP_CODE 8'h0_8
`define LCDC_BANK_MASK 8'hF_8
`define LCDC_BANK_CODE 8'h4_0
`define LCDC_TC_MASK 8'hF_C
`define LCDC_TC_CODE 8'h0_4
`define LCDC_BIAS_MASK 8'hF_8
`define LCDC_BIAS_CODE 8'h1_0
`define LCDC_COL_LAST 7'h5_3
`define LCDC_BANK_LAST 3'h5
`define LCDC_MODE_BLANK 2'h0
`define LCDC_MODE_NORMAL 2'h2
`define LCDC_MODE_ALLON 2'h1
`define LCDC_MODE_INVERSE 2'h3
`define LCDC_BIAS_FACTORY 3'h4
`endif

// >>> rtl/lcdc_vop.v
// Operating-voltage code arithmetic and charge pump enable.
// Assumes static offset inputs already synchronised to clk.
`timescale 1ns/1ps
module lcdc_vop (
   input wire [4:0] pin_voltage_offset,
   input wire [4:0] cal_offset,
   input wire [6:0] host_voltage_value,
   output wire [7:0] operating_voltage_code,
   output wire pump_on
);
   // Both offsets widen by sign, and the sum wraps with no saturation. [RULE13] [RULE14] [RULE15] [RULE20]
   wire [7:0] os_ext = {{3{pin_voltage_offset[4]}}, pin_voltage_offset};
   wire [7:0] cal_ext = {{3{cal_offset[4]}}, cal_offset};
   wire [7:0] pr_dbl = {host_voltage_value, 1'b0};
   assign operating_voltage_code = os_ext + cal_ext + pr_dbl;
   // A zero voltage value stops the pump whatever the offsets say. [RULE17]
   assign pump_on = (host_voltage_value != 7'h0_0);
endmodule

// >>> rtl/lcdc_bias.v
// Bias field decoder giving the n factor of a 1/(n+4) bias.
// Assumes a factory n value from module-maker storage.
`timescale 1ns/1ps
`include "lcdc_defs.vh"
module lcdc_bias (
   input wire [2:0] bias_select,
   input wire [2:0] factory_n,
   output reg [2:0] bias_n,
   output wire [3:0] bias_divisor
);
   always @* begin
      case (bias_select) // [RULE12]
         3'h0: bias_n = 3'h7;
         3'h1: bias_n = 3'h6;
         3'h2: bias_n = 3'h5;
         3'h3: bias_n = 3'h4;
         `LCDC_BIAS_FACTORY: bias_n = factory_n;
         3'h5: bias_n = 3'h2;
         3'h6: bias_n = 3'h1;
         default: bias_n = 3'h0;
      endcase
   end
   assign bias_divisor = {1'b0, bias_n} + 4'h4;
endmodule

// >>> tb/lcdc_config_checker.sv
// Assertions on the configuration state outputs of lcdc_config.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module lcdc_config_checker (
   input wire clk,
   input wire arst_n,
   input wire byte_valid,
   input wire [7:0] byte_data,
   input wire byte_is_data,
   input wire power_down_flag,
   input wire addr_vertical,
   input wire page_extended,
   input wire [1:0] display_mode,
   input wire [2:0] bank_addr,
   input wire [6:0] col_addr,
   input wire [6:0] host_voltage_value,
   input wire ram_we,
   input wire [7:0] ram_wdata,
   input wire generators_on,
   input wire pump_on,
   input wire drivers_grounded
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   wire cmd = byte_valid && !byte_is_data;
   wire base = cmd && !page_extended;
   property p_pd; power_down_flag |-> drivers_grounded && !generators_on && !pump_on; endproperty
   a_pd: assert property (p_pd) else $error("power down outputs");
   property p_fset; cmd && byte_data[7:3] == 5'h04 |=> {power_down_flag, addr_vertical, page_extended} == $past(byte_data[2:0]); endproperty
   a_fset: assert property (p_fset) else $error("function set");
   property p_disp; base && (byte_data & 8'hFA) == 8'h08 |=> display_mode == {$past(byte_data[2]), $past(byte_data[0])}; endproperty
   a_disp: assert property (p_disp) else $error("display mode");
   property p_bank; base && byte_data[7:3] == 5'h08 |=> bank_addr == $past(byte_data[2:0]); endproperty
   a_bank: assert property (p_bank) else $error("bank address");
   property p_col; base && byte_data[7] |=> col_addr == $past(byte_data[6:0]); endproperty
   a_col: assert property (p_col) else $error("column address");
   property p_vpr; cmd && page_extended && byte_data[7] |=> host_voltage_value == $past(byte_data[6:0]) && $stable(col_addr); endproperty
   a_vpr: assert property (p_vpr) else $error("voltage value");
   property p_pump; host_voltage_value == 7'h00 |-> !pump_on; endproperty
   a_pump: assert property (p_pump) else $error("pump with zero value");
   property p_ram; byte_valid && byte_is_data |=> ram_we && ram_wdata == $past(byte_data); endproperty
   a_ram: assert property (p_ram) else $error("ram write");
endmodule
bind lcdc_config lcdc_config_checker chk (.clk, .arst_n, .byte_valid, .byte_data, .byte_is_data, .power_down_flag,
   .addr_vertical, .page_extended, .display_mode, .bank_addr, .col_addr, .host_voltage_value, .ram_we, .ram_wdata,
   .generators_on, .pump_on, .drivers_grounded);

// >>> tb/lcdc_host.sv
// Host model that hands decoded bytes to the block.
// Assumes the block samples a byte on the rising clk edge.
`timescale 1ns/1ps
module lcdc_host (
   input wire clk,
   output reg byte_valid,
   output reg [7:0] byte_data,
   output reg byte_is_data
);
   initial begin
      byte_valid = 1'b0;
      byte_data = 8'h00;
      byte_is_data = 1'b0;
   end
   // Callers keep voltage values inside the coefficient range.
   task send(input logic d, input logic [7:0] b);
      @(negedge clk);
      byte_valid = 1'b1;
      byte_is_data = d; // Commands go with the mode line low.
      byte_data = b;
      @(negedge clk);
      byte_valid = 1'b0;
      // Released lines show the inverse so stale bytes are never mistaken for new ones.
      byte_data = ~b;
      byte_is_data = ~d;
   endtask
endmodule

// >>> tb/lcdc_config_tb.sv
// Self-checking bench for lcdc_config.
// Assumes lcdc_host drives bytes and the checker is bound in.
`timescale 1ns/1ps
module lcdc_config_tb;
   localparam [4:0] CAL = 5'h0F;
   localparam [2:0] FBN = 3'h3;
   reg clk = 1'b0;
   reg arst_n = 1'b0;
   reg [4:0] pin_voltage_offset_pins = 5'h10;
   reg ext_clk_select = 1'b0;
   integer n_errors = 0;
   integer cmp_count = 0;
   wire byte_valid, byte_is_data, power_down_flag, addr_vertical, page_extended, ram_we, osc_enable, pump_on;
   wire drivers_grounded, pixel_blank, pixel_force_on, pixel_invert, generators_on;
   wire [1:0] display_mode, temp_coeff_select;
   wire [2:0] bank_addr, bias_select, bias_n, ram_bank;
   wire [3:0] bias_divisor;
   wire [6:0] col_addr, host_voltage_value, ram_col;
   wire [7:0] byte_data, ram_wdata, operating_voltage_code;
   lcdc_host host (.clk, .byte_valid, .byte_data, .byte_is_data);
   lcdc_config #(.CAL_OFFSET(CAL), .FACTORY_BIAS_N(FBN)) dut (.clk, .arst_n, .byte_valid, .byte_data, .byte_is_data,
      .pin_voltage_offset_pins, .ext_clk_select, .power_down_flag, .addr_vertical, .page_extended, .display_mode,
      .bank_addr, .col_addr, .temp_coeff_select, .bias_select, .host_voltage_value, .ram_we, .ram_bank, .ram_col,
      .ram_wdata, .operating_voltage_code, .bias_n, .bias_divisor, .osc_enable, .generators_on, .pump_on,
      .drivers_grounded, .pixel_force_on, .pixel_invert, .pixel_blank);
   initial begin
      forever #12.5 clk = ~clk;
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task t_reset;
      chk({power_down_flag, addr_vertical, page_extended, display_mode, bank_addr}, 16'h0080);
      chk({temp_coeff_select, bias_select, col_addr}, 16'h0000);
      chk({host_voltage_value, osc_enable, drivers_grounded, pump_on}, 16'h0002);
      $display("reset test done");
   endtask
   task t_pd;
      host.send(1'b1, 8'hAB);
      chk({ram_we, ram_col, ram_wdata}, 16'h80AB);
      chk(col_addr, 16'h0001);
      host.send(1'b0, 8'h22);
      host.send(1'b1, 8'h5A);
      chk({power_down_flag, bank_addr, col_addr}, 16'h0081);
      $display("power down test done");
   endtask
   task t_page;
      host.send(1'b0, 8'h21);
      host.send(1'b0, 8'hB1);
      host.send(1'b0, 8'h43);
      chk({bank_addr, host_voltage_value, pump_on}, 16'h0163);
      host.send(1'b0, 8'h80);
      chk(pump_on, 16'h0000);
      $display("page test done");
   endtask
   task t_ext;
      logic [2:0] n;
      for (int i = 0; i < 8; i++) begin
         n = (i == 4) ? FBN : 3'(7 - i);
         host.send(1'b0, 8'h10 | 8'(i));
         chk({bias_n, bias_divisor}, {n, 4'(n) + 4'h4});
      end
      for (int i = 0; i < 4; i++) begin
         host.send(1'b0, 8'h04 | 8'(i));
         host.send(1'b0, 8'h00);
         chk(temp_coeff_select, 16'(i));
      end
      $display("extended test done");
   endtask
   task t_vop;
      logic [4:0] p;
      host.send(1'b0, 8'hF8);
      for (int k = 0; k < 2; k++) begin
         p = k ? 5'h0F : 5'h10;
         pin_voltage_offset_pins = p;
         repeat (3) @(negedge clk);
         chk(operating_voltage_code, 8'(8'hF0 + {{3{p[4]}}, p} + {{3{CAL[4]}}, CAL}));
      end
      $display("voltage test done");
   endtask
   task t_disp;
      host.send(1'b0, 8'h20);
      for (int i = 0; i < 4; i++) begin
         host.send(1'b0, 8'h08 | {5'h00, i[1], 1'b0, i[0]});
         chk({display_mode, pixel_blank, pixel_force_on, pixel_invert}, {i[1:0], i == 0, i == 1, i == 3});
      end
      $display("display test done");
   endtask
   task t_addr;
      host.send(1'b0, 8'h45);
      host.send(1'b0, 8'hD3);
      chk({bank_addr, col_addr}, 16'h02D3);
      host.send(1'b1, 8'h3C);
      chk({ram_we, bank_addr, col_addr}, 16'h0400);
      chk({ram_bank, ram_col}, 16'h02D3);
      chk(ram_wdata, 16'h003C);
      $display("address test done");
   endtask
   task t_osc;
      chk({osc_enable, generators_on, drivers_grounded, pump_on}, 16'h000D);
      @(negedge clk);
      ext_clk_select = 1'b1;
      @(negedge clk);
      chk(osc_enable, 16'h0000);
      ext_clk_select = 1'b0;
      host.send(1'b0, 8'h12);
      chk(bias_select, 16'h0007);
      host.send(1'b0, 8'h24);
      chk({osc_enable, generators_on, drivers_grounded, pump_on}, 16'h0002);
      host.send(1'b0, 8'h20);
      chk(osc_enable, 16'h0000);
      @(negedge clk);
      chk({osc_enable, generators_on, drivers_grounded, pump_on}, 16'h000D);
      $display("oscillator test done");
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      n_errors = n_errors + 1;
      summarize;
   end
   initial begin
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      t_reset;
      t_pd;
      t_page;
      t_ext;
      t_vop;
      t_disp;
      t_addr;
      t_osc;
      summarize;
   end
endmodule
